/* File: rtl/tdc_params.svh */
`ifndef TDC_PARAMS_SVH
`define TDC_PARAMS_SVH

// Channel count and counter widths.
`define TDC_NCH 3
`define TDC_DTM_W 6
`define TDC_TMR_W 16

// Register byte addresses on the register bus.
`define TDC_ADR_DTC 16'he894
`define TDC_ADR_MSEL 16'he898
`define TDC_ADR_CTR4 16'he89c
`define TDC_ADR_STATE 16'he8b0
`define TDC_ADR_VAL0 16'he8c0
`define TDC_ADR_VAL1 16'he8c4
`define TDC_ADR_VAL2 16'he8c8
`define TDC_ADR_SHD0 16'he8d0
`define TDC_ADR_SHD1 16'he8d4
`define TDC_ADR_SHD2 16'he8d8

// Field positions inside the registers.
`define TDC_DTM_LSB 0
`define TDC_DTE_LSB 8
`define TDC_DTR_LSB 12
`define TDC_CLR_BIT 0

// Reset value of every register in the block.
`define TDC_RST_VAL 16'h0000

// Mode codes of the channel mode select field.
`define TDC_MODE_CAP1 4'h4
`define TDC_MODE_CAP2 4'h5
`define TDC_MODE_CAP3 4'h6
`define TDC_MODE_CAP4 4'h7
`define TDC_MODE_MI5 4'ha
`define TDC_MODE_MI6 4'hb
`define TDC_MODE_MI7 4'hc
`define TDC_MODE_MI8 4'hd
`define TDC_MODE_MI9 4'he
`define TDC_MODE_RSVD 4'hf

`endif

/* File: rtl/tdc_pkg.sv */
package tdc_pkg;
`include "tdc_params.svh"

	// Dead-time counter state of one channel.
	typedef struct packed
	{
		logic [`TDC_DTM_W-1:0] cnt;
	} tdc_dt_state_t;

	// Capture registers of one channel.
	typedef struct packed
	{
		logic [`TDC_TMR_W-1:0] val;
		logic [`TDC_TMR_W-1:0] shd;
	} tdc_cap_state_t;

	// Synchronised pin sample pair used for edge detection.
	typedef struct packed
	{
		logic cur;
		logic prev;
	} tdc_pin_t;

	// Whole state of the top block.
	typedef struct packed
	{
		logic ack;
		logic [31:0] rdata;
		logic [`TDC_NCH-1:0] dte;
		logic [`TDC_DTM_W-1:0] deadtime_reload_value;
		logic [4*`TDC_NCH-1:0] msel;
		logic [`TDC_NCH-1:0] st;
		logic [`TDC_NCH-1:0] c_sync1;
		logic [`TDC_NCH-1:0] c_sync2;
		logic [`TDC_NCH-1:0] c_prev;
		logic [`TDC_NCH-1:0] p_sync1;
		logic [`TDC_NCH-1:0] p_sync2;
		logic [`TDC_NCH-1:0] p_prev;
	} tdc_main_state_t;

	// True for the double-register and multi-input capture codes.
	function automatic logic tdc_is_capture(input logic [3:0] m);
		return (m[3:2] == 2'b01) || ((m >= `TDC_MODE_MI5) && (m <= `TDC_MODE_MI9));
	endfunction
endpackage

/* File: rtl/tdc_deadtime.sv */
module tdc_deadtime
	import tdc_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic reset_n_in,
	input wire logic trigger_in,
	input wire logic enable_in,
	input wire logic clear_in,
	input wire logic [`TDC_DTM_W-1:0] reload_in,
	output logic ready_out,
	output logic run_out
);
	tdc_dt_state_t s;
	tdc_dt_state_t next_s;

	// Single-shot down counter; a running counter ignores new triggers.
	always_comb
	begin
		next_s = s;
		if (clear_in)
			next_s.cnt = '0;
		else if (trigger_in && enable_in && (s.cnt == '0))
			next_s.cnt = reload_in;
		else if (s.cnt != '0)
			next_s.cnt = s.cnt - 1'b1;
	end

	always_ff @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			s <= '0;
		else
			s <= next_s;
	end

	// Ready is low exactly while the counter runs.
	assign run_out = (s.cnt != '0);
	assign ready_out = ~run_out;

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!reset_n_in);

	a_dt_reload_start: assert property (trigger_in && enable_in && !run_out && !clear_in
		|=> s.cnt == $past(reload_in)) else $error("dead-time reload missed");
	a_dt_no_retrig: assert property (run_out && trigger_in && !clear_in
		|=> s.cnt == $past(s.cnt) - 1'b1) else $error("running counter retriggered");
	a_dt_gate_en: assert property (!enable_in && !run_out |=> !run_out)
		else $error("disabled counter started");
	a_dt_clear_stop: assert property (clear_in |=> !run_out)
		else $error("clear did not stop counter");
	c_dt_full_run: cover property (run_out ##1 !run_out);
endmodule

/* File: rtl/tdc_capture.sv */
module tdc_capture
	import tdc_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic reset_n_in,
	input wire logic [3:0] mode_in,
	input wire tdc_pin_t chan_in,
	input wire tdc_pin_t pos_in,
	input wire logic [`TDC_TMR_W-1:0] main_timer_in,
	output logic [`TDC_TMR_W-1:0] value_out,
	output logic [`TDC_TMR_W-1:0] shadow_out,
	output logic capture_set_out,
	output logic edge_irq_out
);
	tdc_cap_state_t s;
	tdc_cap_state_t next_s;
	logic c_rise, c_fall, p_rise, p_fall;
	logic to_val, to_shd, shift;

	// Edges come from comparing this sample with the previous one.
	assign c_rise = chan_in.cur & ~chan_in.prev;
	assign c_fall = ~chan_in.cur & chan_in.prev;
	assign p_rise = pos_in.cur & ~pos_in.prev;
	assign p_fall = ~pos_in.cur & pos_in.prev;

	// Mode decode picks which edge loads which register.
	always_comb
	begin
		to_val = 1'b0;
		to_shd = 1'b0;
		shift = 1'b0;
		next_s = s;
		case (mode_in)
			`TDC_MODE_CAP1: begin to_val = c_rise; to_shd = c_fall; end
			`TDC_MODE_CAP2: shift = c_rise;
			`TDC_MODE_CAP3: shift = c_fall;
			`TDC_MODE_CAP4: shift = c_rise | c_fall;
			`TDC_MODE_MI5: begin to_val = c_rise; to_shd = p_fall; end
			`TDC_MODE_MI6: begin to_val = c_fall; to_shd = p_rise; end
			`TDC_MODE_MI7: begin to_val = c_rise; to_shd = p_rise; end
			`TDC_MODE_MI8: begin to_val = c_fall; to_shd = p_fall; end
			`TDC_MODE_MI9: begin to_val = c_rise | c_fall; to_shd = p_rise | p_fall; end
			default: ;
		endcase
		if (shift)
		begin
			next_s.val = s.shd;
			next_s.shd = main_timer_in;
		end
		if (to_val)
			next_s.val = main_timer_in;
		if (to_shd)
			next_s.shd = main_timer_in;
	end

	always_ff @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			s <= '0;
		else
			s <= next_s;
	end

	assign value_out = s.val;
	assign shadow_out = s.shd;
	assign capture_set_out = to_val | to_shd | shift;
	// In capture modes every channel-pin edge raises the line, not only the capturing one.
	assign edge_irq_out = tdc_is_capture(mode_in) & (c_rise | c_fall);

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!reset_n_in);

	a_cap_mode1_rise: assert property (mode_in == `TDC_MODE_CAP1 && c_rise
		|=> s.val == $past(main_timer_in)) else $error("mode 1 rise not captured");
	a_cap_shift_pair: assert property (shift
		|=> s.val == $past(s.shd) && s.shd == $past(main_timer_in))
		else $error("shift capture wrong");
	a_cap_pos_shadow: assert property (mode_in == `TDC_MODE_MI7 && p_rise
		|=> s.shd == $past(main_timer_in)) else $error("position capture missed");
	a_cap_reserved_idle: assert property (mode_in == `TDC_MODE_RSVD |-> !capture_set_out
		##1 s == $past(s)) else $error("reserved mode acted");
	c_cap_shift: cover property (shift);
endmodule

/* File: rtl/tdc_top.sv */
// Operation
// - Highside active while channel state is 1, lowside active while it is 0.
// - Each channel owns a single-shot 6-bit dead-time down counter triggered by state change.
// - A trigger reloads the counter with the shared reload value and starts it.
// - While counting, ready is low and both channel outputs stay passive.
// - At zero the counter stops and ready goes high, releasing the outputs.
// - Only passive-to-active edges are delayed; active-to-passive edges pass at once.
// - One reload value serves all three channels.
// - Enable bits 8, 9, 10 gate the triggers of channels 0, 1, 2.
// - A running counter accepts no reload, so state changes cannot retrigger it.
// - Read-only bits 12 to 14 show each counter running (1) or stopped (0).
// - Writing 1 to the clear bit of timer control four clears all counters.
// - Mode 0100: rising edge captures timer to value, falling edge to shadow.
// - Modes 0101/0110/0111: active edge shifts shadow to value, timer to shadow.
// - Multi-input modes capture on channel pin to value, position pin to shadow.
// - A capture trigger sets the state bit; software clears it itself.
// - In capture modes every channel pin edge activates that channel's interrupt request line.
// - Mode fields for channels 2, 1, 0 sit at bits 11:8, 7:4, 3:0.
// - Codes 1010 to 1110 pick edge pairs; 1111 does nothing.
module tdc_top
	import tdc_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic reset_n_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [15:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	input wire logic [`TDC_TMR_W-1:0] main_timer_in,
	input wire logic [`TDC_NCH-1:0] compare_state_in,
	input wire logic [`TDC_NCH-1:0] channel_input_pin_in,
	input wire logic [`TDC_NCH-1:0] position_input_pin_in,
	output logic [`TDC_NCH-1:0] highside_out,
	output logic [`TDC_NCH-1:0] lowside_out,
	output logic [`TDC_NCH-1:0] channel_edge_irq_out
);
	tdc_main_state_t s;
	tdc_main_state_t next_s;
	logic bus_req;
	logic wr_now;
	logic dt_clear;
	logic [`TDC_NCH-1:0] sw_clr;
	logic [`TDC_NCH-1:0] dt_trigger;
	logic [`TDC_NCH-1:0] dt_ready;
	logic [`TDC_NCH-1:0] dt_run;
	logic [`TDC_NCH-1:0] cap_set;
	logic [`TDC_NCH-1:0] edge_irq;
	logic [`TDC_TMR_W-1:0] cap_val [`TDC_NCH];
	logic [`TDC_TMR_W-1:0] cap_shd [`TDC_NCH];
	logic [31:0] rd;
	logic [15:0] dtc_word;

	// Merge the low two byte lanes of a write into a 16-bit register image.
	function automatic logic [15:0] lane_merge(input logic [15:0] old,
		input logic [31:0] dat, input logic [3:0] sel);
		logic [15:0] res;
		res = old;
		if (sel[0])
			res[7:0] = dat[7:0];
		if (sel[1])
			res[15:8] = dat[15:8];
		return res;
	endfunction

	// A request is live while cyc and stb are high together.
	assign bus_req = wb_cyc_in & wb_stb_in;
	// Writes land at the edge where the master sees ack, and at no other.
	assign wr_now = bus_req & wb_we_in & s.ack;

	// Packed view of the dead-time control register; run flags are live state.
	always_comb
	begin
		dtc_word = `TDC_RST_VAL;
		dtc_word[`TDC_DTM_LSB +: `TDC_DTM_W] = s.deadtime_reload_value;
		dtc_word[`TDC_DTE_LSB +: `TDC_NCH] = s.dte;
		dtc_word[`TDC_DTR_LSB +: `TDC_NCH] = dt_run;
	end

	// Read decode; unmapped addresses still answer, with zero data.
	always_comb
	begin
		rd = '0;
		case (wb_adr_in)
			`TDC_ADR_DTC: rd[15:0] = dtc_word;
			`TDC_ADR_MSEL: rd[4*`TDC_NCH-1:0] = s.msel;
			`TDC_ADR_STATE: rd[`TDC_NCH-1:0] = s.st;
			`TDC_ADR_VAL0: rd[15:0] = cap_val[0];
			`TDC_ADR_VAL1: rd[15:0] = cap_val[1];
			`TDC_ADR_VAL2: rd[15:0] = cap_val[2];
			`TDC_ADR_SHD0: rd[15:0] = cap_shd[0];
			`TDC_ADR_SHD1: rd[15:0] = cap_shd[1];
			`TDC_ADR_SHD2: rd[15:0] = cap_shd[2];
			default: rd = '0;
		endcase
	end

	// Next-state logic for the bus slave, control registers, pins and state bits.
	always_comb
	begin
		logic [15:0] tmp;
		next_s = s;
		tmp = '0;
		dt_clear = 1'b0;
		sw_clr = '0;
		// Ack rises one cycle after the request and drops the cycle after.
		next_s.ack = bus_req & ~s.ack;
		next_s.rdata = (bus_req & ~s.ack & ~wb_we_in) ? rd : '0;
		// Two flops per pin, then a third stage keeps the previous sample.
		next_s.c_sync1 = channel_input_pin_in;
		next_s.c_sync2 = s.c_sync1;
		next_s.c_prev = s.c_sync2;
		next_s.p_sync1 = position_input_pin_in;
		next_s.p_sync2 = s.p_sync1;
		next_s.p_prev = s.p_sync2;
		if (wr_now)
		begin
			case (wb_adr_in)
				`TDC_ADR_DTC:
				begin
					tmp = lane_merge(dtc_word, wb_dat_in, wb_sel_in);
					// Only one reload value exists for all channels.
					next_s.deadtime_reload_value = tmp[`TDC_DTM_LSB +: `TDC_DTM_W];
					next_s.dte = tmp[`TDC_DTE_LSB +: `TDC_NCH];
				end
				`TDC_ADR_MSEL:
				begin
					tmp = lane_merge({4'h0, s.msel}, wb_dat_in, wb_sel_in);
					next_s.msel = tmp[4*`TDC_NCH-1:0];
				end
				`TDC_ADR_CTR4:
					dt_clear = wb_sel_in[0] & wb_dat_in[`TDC_CLR_BIT];
				`TDC_ADR_STATE:
					sw_clr = wb_dat_in[`TDC_NCH-1:0] & {`TDC_NCH{wb_sel_in[0]}};
				default: ;
			endcase
		end
		// In capture modes a capture sets the bit and software clears it;
		// a set in the same cycle as a clear wins so no event is lost.
		for (int i = 0; i < `TDC_NCH; i++)
		begin
			if (tdc_is_capture(s.msel[4*i +: 4]))
				next_s.st[i] = (s.st[i] & ~sw_clr[i]) | cap_set[i];
			else
				next_s.st[i] = compare_state_in[i];
		end
	end

	always_ff @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			s <= '0;
		else
			s <= next_s;
	end

	// Any change of a state bit fires that channel's dead-time trigger.
	// Using the next value lets the counter load in the same edge as the
	// state, so the newly active output never leaks a one-cycle pulse.
	assign dt_trigger = next_s.st ^ s.st;

	// One dead-time counter and one capture unit per channel.
	generate
		for (genvar g = 0; g < `TDC_NCH; g++)
		begin : g_ch
			tdc_deadtime u_dt
			(
				.clk_sys_in(clk_sys_in),
				.reset_n_in(reset_n_in),
				.trigger_in(dt_trigger[g]),
				.enable_in(s.dte[g]),
				.clear_in(dt_clear),
				.reload_in(s.deadtime_reload_value),
				.ready_out(dt_ready[g]),
				.run_out(dt_run[g])
			);
			tdc_capture u_cap
			(
				.clk_sys_in(clk_sys_in),
				.reset_n_in(reset_n_in),
				.mode_in(s.msel[4*g +: 4]),
				.chan_in('{cur: s.c_sync2[g], prev: s.c_prev[g]}),
				.pos_in('{cur: s.p_sync2[g], prev: s.p_prev[g]}),
				.main_timer_in(main_timer_in),
				.value_out(cap_val[g]),
				.shadow_out(cap_shd[g]),
				.capture_set_out(cap_set[g]),
				.edge_irq_out(edge_irq[g])
			);
		end
	endgenerate

	// Outputs are gated by ready, so only the rising edge waits on dead time;
	// a falling output follows its state bit in the same cycle.
	assign highside_out = s.st & dt_ready;
	assign lowside_out = ~s.st & dt_ready;
	assign channel_edge_irq_out = edge_irq;
	assign wb_ack_out = s.ack;
	assign wb_dat_out = s.rdata;

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!reset_n_in);

	a_side_follow_state: assert property (highside_out[0] |-> s.st[0] && !lowside_out[0])
		else $error("highside not tied to state");
	a_low_follow_state: assert property (lowside_out[1] |-> !s.st[1] && !highside_out[1])
		else $error("lowside not tied to state");
	a_dt_hold_passive: assert property (dt_run[0] |-> !highside_out[0] && !lowside_out[0])
		else $error("output active during dead time");
	a_dt_release_out: assert property (!dt_run[2] |-> (highside_out[2] ^ lowside_out[2]))
		else $error("ready channel not driving");
	a_off_no_delay: assert property ($fell(s.st[0]) |-> !highside_out[0])
		else $error("active-to-passive edge delayed");
	a_dt_start_delay: assert property (s.dte[1] && !dt_run[1] && dt_trigger[1]
		&& !dt_clear && s.deadtime_reload_value != '0 |=> dt_run[1]) else $error("enabled trigger ignored");
	a_run_flag_read: assert property (bus_req && !wb_we_in && !s.ack && wb_adr_in == `TDC_ADR_DTC
		|=> wb_dat_out[`TDC_DTR_LSB +: `TDC_NCH] == $past(dt_run))
		else $error("run flags misreported");
	a_ctr4_clear: assert property (dt_clear |=> dt_run == '0)
		else $error("dead-time clear ignored");
	a_state_set_wins: assert property (cap_set[0] && tdc_is_capture(s.msel[3:0])
		|=> s.st[0]) else $error("capture did not set state");
	a_edge_irq_line: assert property (tdc_is_capture(s.msel[7:4])
		&& (s.c_sync2[1] != s.c_prev[1]) |-> channel_edge_irq_out[1])
		else $error("pin edge without request");
	a_msel_write: assert property (wr_now && wb_adr_in == `TDC_ADR_MSEL && wb_sel_in[1:0] == 2'b11
		|=> s.msel == $past(wb_dat_in[11:0])) else $error("mode field not stored");
	a_ack_single: assert property (wb_ack_out |=> !wb_ack_out)
		else $error("ack held two cycles");

	// Both switches follow the state bit on every leg.
	// A crossed wire on one leg would short that leg, so each leg is checked.
	a_high_follow_ch1: assert property (highside_out[1] |-> s.st[1] && !lowside_out[1])
		else $error("highside 1 not tied to state");
	a_high_follow_ch2: assert property (highside_out[2] |-> s.st[2] && !lowside_out[2])
		else $error("highside 2 not tied to state");
	a_low_follow_ch0: assert property (lowside_out[0] |-> !s.st[0] && !highside_out[0])
		else $error("lowside 0 not tied to state");
	a_low_follow_ch2: assert property (lowside_out[2] |-> !s.st[2] && !highside_out[2])
		else $error("lowside 2 not tied to state");

	// Dead time keeps both switches off, then hands the leg back to the state bit.
	// Ready is the plain inverse of run, so no leg can see a stale ready.
	a_hold_passive_ch1: assert property (dt_run[1] |-> !highside_out[1] && !lowside_out[1])
		else $error("output 1 active in dead time");
	a_hold_passive_ch2: assert property (dt_run[2] |-> !highside_out[2] && !lowside_out[2])
		else $error("output 2 active in dead time");
	a_release_ch0: assert property (!dt_run[0] |-> (highside_out[0] ^ lowside_out[0]))
		else $error("ready channel 0 not driving");
	a_release_ch1: assert property (!dt_run[1] |-> (highside_out[1] ^ lowside_out[1]))
		else $error("ready channel 1 not driving");
	a_ready_run_pair: assert property (dt_ready == ~dt_run)
		else $error("ready and run disagree");

	// Switch-off is never delayed, whichever side is turning off.
	a_off_no_delay_ch1: assert property ($fell(s.st[1]) |-> !highside_out[1])
		else $error("highside 1 off delayed");
	a_off_no_delay_ch2: assert property ($fell(s.st[2]) |-> !highside_out[2])
		else $error("highside 2 off delayed");
	a_low_off_ch0: assert property ($rose(s.st[0]) |-> !lowside_out[0])
		else $error("lowside 0 off delayed");
	a_low_off_ch1: assert property ($rose(s.st[1]) |-> !lowside_out[1])
		else $error("lowside 1 off delayed");
	a_low_off_ch2: assert property ($rose(s.st[2]) |-> !lowside_out[2])
		else $error("lowside 2 off delayed");

	// A trigger starts only an enabled, idle counter with a nonzero reload.
	a_start_delay_ch0: assert property (s.dte[0] && !dt_run[0] && dt_trigger[0]
		&& !dt_clear && s.deadtime_reload_value != '0 |=> dt_run[0]) else $error("trigger 0 ignored");
	a_start_delay_ch2: assert property (s.dte[2] && !dt_run[2] && dt_trigger[2]
		&& !dt_clear && s.deadtime_reload_value != '0 |=> dt_run[2]) else $error("trigger 2 ignored");
	a_dis_no_delay0: assert property (!s.dte[0] && !dt_run[0] |=> !dt_run[0])
		else $error("disabled counter 0 started");
	a_dis_no_delay1: assert property (!s.dte[1] && !dt_run[1] |=> !dt_run[1])
		else $error("disabled counter 1 started");
	a_dis_no_delay2: assert property (!s.dte[2] && !dt_run[2] |=> !dt_run[2])
		else $error("disabled counter 2 started");

	// Dead-time control writes land one field per byte lane.
	a_dtm_shared: assert property (wr_now && wb_adr_in == `TDC_ADR_DTC && wb_sel_in[0]
		|=> s.deadtime_reload_value == $past(wb_dat_in[5:0])) else $error("reload value not stored");
	a_dte_write: assert property (wr_now && wb_adr_in == `TDC_ADR_DTC && wb_sel_in[1]
		|=> s.dte == $past(wb_dat_in[10:8])) else $error("enable bits not stored");
	a_state_clear: assert property (wr_now && wb_adr_in == `TDC_ADR_STATE
		&& wb_sel_in[0] && wb_dat_in[0] && tdc_is_capture(s.msel[3:0]) && !cap_set[0]
		|=> !s.st[0]) else $error("state bit not cleared");

	// Capture sets the state bit, and pin edges raise the request, on every channel.
	a_state_set_ch1: assert property (cap_set[1] && tdc_is_capture(s.msel[7:4])
		|=> s.st[1]) else $error("capture 1 did not set state");
	a_state_set_ch2: assert property (cap_set[2] && tdc_is_capture(s.msel[11:8])
		|=> s.st[2]) else $error("capture 2 did not set state");
	a_edge_irq_ch0: assert property (tdc_is_capture(s.msel[3:0])
		&& (s.c_sync2[0] != s.c_prev[0]) |-> channel_edge_irq_out[0]) else $error("irq 0 lost");
	a_edge_irq_ch2: assert property (tdc_is_capture(s.msel[11:8])
		&& (s.c_sync2[2] != s.c_prev[2]) |-> channel_edge_irq_out[2]) else $error("irq 2 lost");
	a_irq_gate_ch0: assert property (!tdc_is_capture(s.msel[3:0]) |-> !channel_edge_irq_out[0])
		else $error("irq 0 outside capture");

	// A read is taken at the edge where the request stands without ack.
	logic rd_take;
	assign rd_take = bus_req & ~wb_we_in & ~s.ack;
	a_ack_after_req: assert property (bus_req && !wb_ack_out |=> wb_ack_out)
		else $error("request not acknowledged");
	a_rdata_idle: assert property (!wb_ack_out |-> wb_dat_out == '0)
		else $error("read data outside ack");
	a_val_read_ch0: assert property (rd_take && wb_adr_in == `TDC_ADR_VAL0
		|=> wb_dat_out == {16'h0000, $past(cap_val[0])}) else $error("value 0 misread");
	a_val_read_ch1: assert property (rd_take && wb_adr_in == `TDC_ADR_VAL1
		|=> wb_dat_out == {16'h0000, $past(cap_val[1])}) else $error("value 1 misread");
	a_val_read_ch2: assert property (rd_take && wb_adr_in == `TDC_ADR_VAL2
		|=> wb_dat_out == {16'h0000, $past(cap_val[2])}) else $error("value 2 misread");
	a_shd_read_ch0: assert property (rd_take && wb_adr_in == `TDC_ADR_SHD0
		|=> wb_dat_out == {16'h0000, $past(cap_shd[0])}) else $error("shadow 0 misread");
	a_shd_read_ch1: assert property (rd_take && wb_adr_in == `TDC_ADR_SHD1
		|=> wb_dat_out == {16'h0000, $past(cap_shd[1])}) else $error("shadow 1 misread");
	a_shd_read_ch2: assert property (rd_take && wb_adr_in == `TDC_ADR_SHD2
		|=> wb_dat_out == {16'h0000, $past(cap_shd[2])}) else $error("shadow 2 misread");
	a_msel_read: assert property (rd_take && wb_adr_in == `TDC_ADR_MSEL
		|=> wb_dat_out == {20'h0_0000, $past(s.msel)}) else $error("mode misread");
	a_state_read: assert property (rd_take && wb_adr_in == `TDC_ADR_STATE
		|=> wb_dat_out == {29'h0000_0000, $past(s.st)}) else $error("state misread");
	a_ctr4_read_zero: assert property (rd_take && wb_adr_in == `TDC_ADR_CTR4
		|=> wb_dat_out == '0) else $error("clear register read nonzero");

	// The pin chains shift one stage a cycle, so each edge is seen exactly once.
	a_sync_chan: assert property (s.c_sync2 == $past(s.c_sync1) && s.c_prev == $past(s.c_sync2))
		else $error("channel pin chain skipped");
	a_sync_pos: assert property (s.p_sync2 == $past(s.p_sync1) && s.p_prev == $past(s.p_sync2))
		else $error("position pin chain skipped");

	c_bus_write: cover property (wr_now);
	c_dt_delay: cover property (dt_run[0] ##1 !dt_run[0] ##0 highside_out[0]);
	c_capture_set: cover property (cap_set[2]);
endmodule

/* File: dv/tdc_pin_source.sv */
module tdc_pin_source
(
	input wire logic clk_sys_in,
	input wire logic [2:0] chan_req_in,
	input wire logic [2:0] pos_req_in,
	input wire logic [1:0] lag_in,
	input wire logic [2:0] highside_in,
	input wire logic [2:0] lowside_in,
	output logic [2:0] chan_pin_out,
	output logic [2:0] pos_pin_out,
	output logic shoot_out
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [5:0] pipe [0:3];

	// Sources start idle low so the pins never float into the synchronisers.
	initial
	begin
		for (int i = 0; i < 4; i++)
			pipe[i] = 6'h00;
	end

	// A requested level settles one to four cycles late, as a slow sensor would.
	always @(posedge clk_sys_in)
	begin
		pipe[0] <= {pos_req_in, chan_req_in};
		pipe[1] <= pipe[0];
		pipe[2] <= pipe[1];
		pipe[3] <= pipe[2];
	end

	assign {pos_pin_out, chan_pin_out} = pipe[lag_in];

	// Both switches of one leg on together would short the supply rail.
	assign shoot_out = |(highside_in & lowside_in);
endmodule

/* File: dv/tb_timer_channel_deadtime_capture.sv */
`include "tdc_params.svh"
module tb_timer_channel_deadtime_capture;
	import tdc_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	logic clk_sys_in = 1'b0;
	logic reset_n_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out, shoot, hit;
	logic [15:0] wb_adr_in, main_timer_in, rnd, ev, es;
	logic [3:0] wb_sel_in, m;
	logic [31:0] wb_dat_in, wb_dat_out, rd;
	logic [2:0] compare_state_in, chan_pin, pos_pin, chan_req, pos_req;
	logic [2:0] highside_out, lowside_out, channel_edge_irq_out;
	logic [1:0] lag;
	logic [3:0] modes [10] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};
	int err_count, checks_done, irq_n, shoot_n, k, deadtime_reload_value;

	always #10 clk_sys_in = ~clk_sys_in;

	tdc_top u_tdc_top (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .wb_cyc_in(wb_cyc_in),
		.wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in),
		.wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
		.main_timer_in(main_timer_in), .compare_state_in(compare_state_in),
		.channel_input_pin_in(chan_pin), .position_input_pin_in(pos_pin),
		.highside_out(highside_out), .lowside_out(lowside_out),
		.channel_edge_irq_out(channel_edge_irq_out));

	tdc_pin_source u_tdc_pin_source (.clk_sys_in(clk_sys_in), .chan_req_in(chan_req),
		.pos_req_in(pos_req), .lag_in(lag), .highside_in(highside_out),
		.lowside_in(lowside_out), .chan_pin_out(chan_pin), .pos_pin_out(pos_pin),
		.shoot_out(shoot));

	// Pulses are tallied every cycle so a one-cycle request is never missed.
	always @(posedge clk_sys_in)
	begin
		if (channel_edge_irq_out[0] === 1'b1)
			irq_n <= irq_n + 1;
		if (shoot === 1'b1)
			shoot_n <= shoot_n + 1;
	end

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checks_done++;
		if (seen !== want)
		begin
			err_count++;
			$display("BAD t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask

	task stop_test;
		if (err_count == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// One classic single cycle; the request is held until ack is sampled high.
	task automatic wb(input logic we, input logic [15:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys_in);
		wb_cyc_in <= 1'b1;
		wb_stb_in <= 1'b1;
		wb_we_in <= we;
		wb_adr_in <= a;
		wb_dat_in <= d;
		do
		begin
			@(posedge clk_sys_in);
			n++;
		end
		while (wb_ack_out !== 1'b1 && n < 20);
		rd = wb_dat_out;
		if (n >= 20)
			err_count++;
		wb_cyc_in <= 1'b0;
		wb_stb_in <= 1'b0;
		wb_we_in <= 1'b0;
	endtask

	// Flips one state source and counts cycles until the going-active switch turns on.
	task automatic dt_edge(input int c, input logic v, input int want);
		@(posedge clk_sys_in);
		compare_state_in[c] <= v;
		@(posedge clk_sys_in);
		k = 0;
		do
		begin
			@(negedge clk_sys_in);
			k++;
			if (k == 1)
				check(v ? lowside_out[c] : highside_out[c], 1'b0);
		end
		while ((v ? highside_out[c] : lowside_out[c]) !== 1'b1 && k < 100);
		check(k, want);
	endtask

	// One pin edge on channel zero, with the expected capture registers updated alongside.
	task automatic cap_ev(input logic [3:0] md, input bit pos, input bit rise);
		logic cv, cs, sh;
		logic [4:0] x;
		rnd = lfsr(rnd);
		@(posedge clk_sys_in);
		main_timer_in <= rnd;
		lag <= rnd[1:0];
		if (pos)
			pos_req[0] <= rise;
		else
			chan_req[0] <= rise;
		repeat (12) @(posedge clk_sys_in);
		cv = (md == 4'h4) && !pos && rise;
		cs = (md == 4'h4) && !pos && !rise;
		sh = (md inside {4'h5, 4'h6, 4'h7}) && !pos && (md == 4'h7 || rise == (md == 4'h5));
		if (md inside {[4'ha:4'he]})
		begin
			x = pos ? (rise ? 5'b10110 : 5'b11001) : (rise ? 5'b10101 : 5'b11010);
			cv = x[md - 4'ha] && !pos;
			cs = x[md - 4'ha] && pos;
		end
		if (sh)
			ev = es;
		if (sh || cs)
			es = rnd;
		if (cv)
			ev = rnd;
		hit = hit | cv | cs | sh;
	endtask

	initial
	begin
		repeat (20000) @(posedge clk_sys_in);
		err_count++;
		stop_test;
	end

	initial
	begin
		{reset_n_in, wb_cyc_in, wb_stb_in, wb_we_in, lag} = '0;
		{wb_adr_in, wb_dat_in, main_timer_in, ev, es} = '0;
		{compare_state_in, chan_req, pos_req} = '0;
		wb_sel_in = 4'h3;
		rnd = 16'd27015;
		repeat (4) @(posedge clk_sys_in);
		reset_n_in <= 1'b1;
		wb(0, `TDC_ADR_DTC, 0);
		check(rd, 32'h0000_0000);
		wb(0, 16'he800, 0);
		check(rd, 32'h0000_0000);
		wb(1, `TDC_ADR_DTC, 32'h0000_ffff);
		wb(0, `TDC_ADR_DTC, 0);
		check(rd, 32'h0000_073f);
		wb(1, `TDC_ADR_MSEL, 32'h0000_fedc);
		wb(0, `TDC_ADR_MSEL, 0);
		check(rd, 32'h0000_0edc);
		wb(1, `TDC_ADR_MSEL, 0);
		// Random shared reload; channel one is left without delay.
		rnd = lfsr(rnd);
		deadtime_reload_value = 2 + rnd[3:0];
		wb(1, `TDC_ADR_DTC, 32'h0000_0500 + deadtime_reload_value);
		for (int c = 0; c < 3; c++)
		begin
			dt_edge(c, 1'b1, c == 1 ? 1 : deadtime_reload_value + 1);
			dt_edge(c, 1'b0, c == 1 ? 1 : deadtime_reload_value + 1);
		end
		// A long delay, flipped back while running, must end on its first schedule.
		wb(1, `TDC_ADR_DTC, 32'h0000_0128);
		@(posedge clk_sys_in);
		compare_state_in[0] <= 1'b1;
		wb(0, `TDC_ADR_DTC, 0);
		check(rd, 32'h0000_1128);
		compare_state_in[0] <= 1'b0;
		repeat (38) @(posedge clk_sys_in);
		wb(0, `TDC_ADR_DTC, 0);
		check(rd, 32'h0000_0128);
		compare_state_in[0] <= 1'b1;
		wb(1, `TDC_ADR_CTR4, 1);
		wb(0, `TDC_ADR_DTC, 0);
		check(rd, 32'h0000_0128);
		compare_state_in[0] <= 1'b0;
		wb(1, `TDC_ADR_DTC, 0);
		// Every capture code, then the reserved one, on a fixed edge sequence.
		for (int i = 0; i < 10; i++)
		begin
			m = modes[i];
			wb(1, `TDC_ADR_MSEL, {28'h0, m});
			hit = 1'b0;
			k = irq_n;
			cap_ev(m, 0, 1);
			cap_ev(m, 1, 1);
			cap_ev(m, 0, 0);
			cap_ev(m, 1, 0);
			wb(0, `TDC_ADR_VAL0, 0);
			check(rd, {16'h0, ev});
			wb(0, `TDC_ADR_SHD0, 0);
			check(rd, {16'h0, es});
			wb(0, `TDC_ADR_STATE, 0);
			check(rd[0], hit);
			check(irq_n - k, m == 4'hf ? 0 : 2);
			wb(1, `TDC_ADR_STATE, 1);
		end
		check(shoot_n, 0);
		stop_test;
	end
endmodule
